// >>> verilog/perf_mon_pkg.sv
// Package: register map, field positions and timing for the DS3/E3 error counter bank
package perf_mon_pkg;
	localparam int ADDR_W = 12;
	// Printed offsets are not word aligned: they are indices, byte address is four times
	localparam logic [11:0] IDX_CHANGE = 12'h210;
	localparam logic [11:0] IDX_STATUS = 12'h211;
	localparam logic [11:0] IDX_LCV_LO = 12'h214;
	localparam logic [11:0] IDX_LCV_HI = 12'h215;
	localparam logic [11:0] IDX_FRM_LO = 12'h216;
	localparam logic [11:0] IDX_FRM_HI = 12'h217;
	localparam logic [11:0] IDX_SUM_LO = 12'h218;
	localparam logic [11:0] IDX_SUM_HI = 12'h219;
	localparam logic [11:0] IDX_PAR_LO = 12'h21A;
	localparam logic [11:0] IDX_PAR_HI = 12'h21B;
	localparam logic [11:0] IDX_PTH_LO = 12'h21C;
	localparam logic [11:0] IDX_PTH_HI = 12'h21D;
	localparam logic [11:0] IDX_FEB_LO = 12'h21E;
	localparam logic [11:0] IDX_FEB_HI = 12'h21F;
	localparam logic [11:0] IDX_GLOBAL = 12'h004;
	localparam logic [11:0] IDX_CONFIG = 12'h200;
	// Widths of the six counters
	localparam int LCV_W = 16;
	localparam int FRM_W = 10;
	localparam int SUM_W = 16;
	localparam int PAR_W = 16;
	localparam int PTH_W = 14;
	localparam int FEB_W = 14;
	// Status register fields
	localparam int ST_OVR = 0;
	localparam int ST_DONE = 1;
	localparam int ST_IE = 2;
	// Configuration register fields
	localparam int CF_E3 = 0;
	localparam int CF_G832 = 1;
	localparam int CF_SUMSEL = 2;
	localparam int CF_ZDET = 3;
	localparam logic [3:0] CONFIG_RESET = 4'h0;
	// Information block length in bits and transfer depth in cycles
	localparam int BLOCK_BITS = 85;
	localparam int XFER_CYCLES = 3;
endpackage

// >>> verilog/perf_mon.sv
// Performance-monitoring error counter bank for one DS3/E3 receive channel
`timescale 1ns/1ps
// Functional notes
// - Count line code violations in 16 bits, low and high holding bytes.
// - Any write to channel or global update register latches counts, restarts them.
// - Events coinciding with the poll are counted; with the counter full the snapshot wraps to zero.
// - Holding registers are loaded within three clocks after the poll write.
// - Count framing errors in 10 bits; upper six high-byte bits read zero.
// - Excessive zeros counted at most once per 85-bit block.
// - Excessive zeros counted only when select and detect enable are both one.
// - With select zero, count 85-bit blocks holding any line code violation.
// - E3 mode holds the summed counter at zero.
// - Count parity errors in 16 bits: P-bit in DS3, BIP-8 in E3 G.832.
// - E3 G.751 holds the parity count at zero.
// - Count DS3 path parity errors in 14 bits; top two high bits zero.
// - Any E3 mode holds the path parity count at zero.
// - Count far end block errors in 14 bits in DS3 or E3 G.832.
// - E3 G.751 holds the far end block error count at zero.
// - Each count reads as low byte then high byte at next offset.
// - Transfer sets done bit; interrupt when enabled; clear on status read.
// - Transfer with done still set raises overrun, cleared on status read.
// - Per-counter change bit shows events in latest interval.
module perf_mon
(
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [perf_mon_pkg::ADDR_W+1:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_lcv_evt,
	input wire logic i_frm_evt,
	input wire logic i_zeros_evt,
	input wire logic i_par_evt,
	input wire logic i_pth_evt,
	input wire logic i_feb_evt,
	input wire logic i_block_end,
	output logic o_irq
);
	import perf_mon_pkg::*;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic req;
	logic [11:0] idx;
	logic wr;
	logic rd;
	logic chan_hit;
	logic poll;
	assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign idx = i_wb_adr[ADDR_W+1:2];
	assign wr = req && i_wb_we;
	assign rd = req && !i_wb_we;
	assign chan_hit = (idx >= IDX_CHANGE) && (idx <= IDX_FEB_HI);
	assign poll = wr && (chan_hit || idx == IDX_GLOBAL);

	logic [3:0] config_q;
	logic e3;
	logic g751;
	assign e3 = config_q[CF_E3];
	assign g751 = config_q[CF_E3] && !config_q[CF_G832];

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			config_q <= CONFIG_RESET;
		else if (wr && idx == IDX_CONFIG && i_wb_sel[0])
			config_q <= i_wb_dat[3:0];
	end

	// ----------------------------------------------------------------
	// Summed block events
	// ----------------------------------------------------------------
	logic block_hit_q;
	logic sum_src;
	logic sum_evt;
	// Select picks zeros (only with detect enable) or line code violations
	assign sum_src = config_q[CF_SUMSEL] ? (i_zeros_evt && config_q[CF_ZDET]) : i_lcv_evt;
	// Count once at block end if anything hit during the block
	assign sum_evt = i_block_end && (block_hit_q || sum_src) && !e3;

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			block_hit_q <= 1'b0;
		else if (i_block_end)
			block_hit_q <= 1'b0;
		else if (sum_src)
			block_hit_q <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Counters and holding registers
	// ----------------------------------------------------------------
	localparam int NCNT = 6;
	logic [NCNT-1:0] evt;
	assign evt[0] = i_lcv_evt;
	assign evt[1] = i_frm_evt;
	assign evt[2] = sum_evt;
	assign evt[3] = i_par_evt && !g751;
	assign evt[4] = i_pth_evt && !e3;
	assign evt[5] = i_feb_evt && !g751;

	logic [15:0] hold [NCNT];
	logic [NCNT-1:0] change_q;
	logic xfer;

	// Transfer pipeline: poll, snapshot, load holding registers
	logic [XFER_CYCLES-2:0] xfer_pipe_q;
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			xfer_pipe_q <= '0;
		else
			xfer_pipe_q <= {xfer_pipe_q[XFER_CYCLES-3:0], poll};
	end
	assign xfer = xfer_pipe_q[0];

	genvar g;
	generate
		for (g = 0; g < NCNT; g++)
		begin : gen_cnt
			localparam int W = (g == 0) ? LCV_W : (g == 1) ? FRM_W : (g == 2) ? SUM_W :
				(g == 3) ? PAR_W : (g == 4) ? PTH_W : FEB_W;
			logic [W-1:0] cnt_q;
			logic [W-1:0] snap_q;
			logic hit_q;
			logic snap_hit_q;
			// Poll cycle: snapshot including a coincident event, restart from zero
			always_ff @(posedge i_mclk or posedge i_reset)
			begin
				if (i_reset)
				begin
					cnt_q <= '0;
					hit_q <= 1'b0;
					snap_q <= '0;
					snap_hit_q <= 1'b0;
				end
				else if (poll)
				begin
					snap_q <= cnt_q + W'(evt[g]);
					snap_hit_q <= hit_q || evt[g];
					cnt_q <= '0;
					hit_q <= 1'b0;
				end
				else if (evt[g])
				begin
					if (cnt_q != '1)
						cnt_q <= cnt_q + W'(1);
					hit_q <= 1'b1;
				end
			end
			always_ff @(posedge i_mclk or posedge i_reset)
			begin
				if (i_reset)
				begin
					hold[g] <= 16'h0000;
					change_q[g] <= 1'b0;
				end
				else if (xfer)
				begin
					hold[g] <= 16'(snap_q);
					change_q[g] <= snap_hit_q;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Status
	// ----------------------------------------------------------------
	logic done_q;
	logic ovr_q;
	logic ie_q;
	logic st_rd;
	assign st_rd = rd && idx == IDX_STATUS;

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			ie_q <= 1'b0;
		else if (wr && idx == IDX_STATUS && i_wb_sel[0])
			ie_q <= i_wb_dat[ST_IE];
	end

	// Set wins over the read clear
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			done_q <= 1'b0;
		else if (xfer)
			done_q <= 1'b1;
		else if (st_rd)
			done_q <= 1'b0;
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			ovr_q <= 1'b0;
		else if (xfer && done_q)
			ovr_q <= 1'b1;
		else if (st_rd)
			ovr_q <= 1'b0;
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			o_irq <= 1'b0;
		else
			o_irq <= ie_q && (done_q || xfer) && !(st_rd && !xfer);
	end

	// ----------------------------------------------------------------
	// Read data and acknowledge
	// ----------------------------------------------------------------
	logic [7:0] rd_byte;
	always_comb
	begin
		rd_byte = 8'h00;
		unique case (idx)
			IDX_CHANGE: rd_byte = {2'b00, change_q[0], change_q[1], change_q[2],
				change_q[3], change_q[4], change_q[5]};
			IDX_STATUS: rd_byte = {5'b00000, ie_q, done_q, ovr_q};
			IDX_CONFIG: rd_byte = {4'h0, config_q};
			IDX_LCV_LO: rd_byte = hold[0][7:0];
			IDX_LCV_HI: rd_byte = hold[0][15:8];
			IDX_FRM_LO: rd_byte = hold[1][7:0];
			IDX_FRM_HI: rd_byte = hold[1][15:8];
			IDX_SUM_LO: rd_byte = hold[2][7:0];
			IDX_SUM_HI: rd_byte = hold[2][15:8];
			IDX_PAR_LO: rd_byte = hold[3][7:0];
			IDX_PAR_HI: rd_byte = hold[3][15:8];
			IDX_PTH_LO: rd_byte = hold[4][7:0];
			IDX_PTH_HI: rd_byte = hold[4][15:8];
			IDX_FEB_LO: rd_byte = hold[5][7:0];
			IDX_FEB_HI: rd_byte = hold[5][15:8];
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end
		else
		begin
			o_wb_ack <= req;
			o_wb_dat <= rd ? {24'h000000, rd_byte} : 32'h0000_0000;
		end
	end
endmodule

// >>> dv/err_src.sv
// Framer stand-in that sends error event pulses and block marks
`timescale 1ns/1ps
module err_src
(
	input wire logic i_mclk,
	output logic [5:0] o_evt,
	output logic o_block_end
);
	initial
	begin
		o_evt = 6'h00;
		o_block_end = 1'b0;
	end
	// Separate one-cycle pulses so each is one event
	task automatic burst(input logic [5:0] m, input int n);
		repeat (n)
		begin
			@(posedge i_mclk) o_evt <= m;
			@(posedge i_mclk) o_evt <= 6'h00;
		end
	endtask
	task automatic mark();
		@(posedge i_mclk) o_block_end <= 1'b1;
		@(posedge i_mclk) o_block_end <= 1'b0;
	endtask
endmodule

// >>> dv/perf_mon_sva.sv
// Checker for the counter bank bus and interrupt ports
`timescale 1ns/1ps
module perf_mon_sva
import perf_mon_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [ADDR_W+1:0] i_wb_adr,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	input wire logic o_irq
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	wire [11:0] idx = i_wb_adr[13:2];
	wire rd = o_wb_ack && !i_wb_we;
	wire wack = o_wb_ack && i_wb_we;
	sequence s_take;
		i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence
	AST_ACK_NEXT: assert property (s_take |=> o_wb_ack) else $error("ack missing");
	AST_ACK_ONE: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
	AST_UPPER_ZERO: assert property (o_wb_dat[31:8] == 24'h000000)
		else $error("upper data bits set");
	AST_WR_NODATA: assert property (wack |-> o_wb_dat == 32'h0) else $error("data on write");
	AST_FRM_HI: assert property (rd && idx == IDX_FRM_HI |-> o_wb_dat[7:2] == 6'h00)
		else $error("framing high byte unused bits set");
	AST_PTH_HI: assert property (rd && idx == IDX_PTH_HI |-> o_wb_dat[7:6] == 2'h0)
		else $error("path parity high byte unused bits set");
	AST_FEB_HI: assert property (rd && idx == IDX_FEB_HI |-> o_wb_dat[7:6] == 2'h0)
		else $error("block error high byte unused bits set");
	AST_IRQ_RISE: assert property ($rose(o_irq) |-> $past(wack) || $past(wack, 2))
		else $error("irq rose without a write");
	AST_IRQ_FALL: assert property ($fell(o_irq) |-> o_wb_ack || $past(o_wb_ack))
		else $error("irq fell without an access");
endmodule
bind perf_mon perf_mon_sva u_sva (.i_mclk(i_mclk), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat),
	.o_wb_ack(o_wb_ack), .o_irq(o_irq));

// >>> dv/tb_perf_mon.sv
// Self-checking bench for the error counter bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_perf_mon;
	import perf_mon_pkg::*;
	logic i_mclk = 1'b0;
	logic i_reset = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [13:0] adr = 14'h0000;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic irq;
	logic [5:0] evt;
	logic blk;
	int miscompares = 0;
	int n_compared = 0;
	int cyc_n = 0;
	logic [15:0] ex [6];
	logic [7:0] cfgs [5] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h0C};
	always #2.5 i_mclk = ~i_mclk;
	perf_mon DUT (.i_mclk(i_mclk), .i_reset(i_reset), .i_wb_cyc(cyc), .i_wb_stb(cyc),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wdat), .o_wb_dat(rdat),
		.o_wb_ack(ack), .i_lcv_evt(evt[5]), .i_frm_evt(evt[4]), .i_zeros_evt(evt[3]),
		.i_par_evt(evt[2]), .i_pth_evt(evt[1]), .i_feb_evt(evt[0]), .i_block_end(blk),
		.o_irq(irq));
	err_src fr (.i_mclk(i_mclk), .o_evt(evt), .o_block_end(blk));
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge i_mclk)
	begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 20000)
		begin
			miscompares++;
			finish_test();
		end
	end
	// Classic cycle; ack and read data are taken at the rising edge, then released
	task automatic acc(input logic w, input logic [11:0] ix, input logic [7:0] d,
		output logic [31:0] q);
		int t;
		t = 0;
		@(posedge i_mclk);
		cyc <= 1'b1;
		we <= w;
		adr <= {ix, 2'b00};
		wdat <= {24'h0, d};
		do @(posedge i_mclk); while (ack !== 1'b1 && ++t < 50);
		q = rdat;
		cyc <= 1'b0;
		if (t >= 50)
			miscompares++;
	endtask
	task automatic wr(input logic [11:0] ix, input logic [7:0] d);
		logic [31:0] q;
		acc(1'b1, ix, d, q);
	endtask
	task automatic chk_cnt();
		logic [31:0] q;
		logic [5:0] ch;
		for (int i = 0; i < 6; i++)
		begin
			acc(1'b0, IDX_LCV_LO + 12'(2 * i), 8'h00, q);
			`CHK("count_lo", {24'h0, ex[i][7:0]}, q)
			acc(1'b0, IDX_LCV_LO + 12'(2 * i + 1), 8'h00, q);
			`CHK("count_hi", {24'h0, ex[i][15:8]}, q)
			ch[5 - i] = (ex[i] != 16'h0);
		end
		acc(1'b0, IDX_CHANGE, 8'h00, q);
		`CHK("change", {26'h0, ch}, q)
	endtask
	initial
	begin
		logic [31:0] q;
		logic [31:0] q2;
		logic e3;
		repeat (2) @(posedge i_mclk);
		i_reset <= 1'b0;
		acc(1'b0, IDX_STATUS, 8'h00, q);
		`CHK("status_reset", 32'h0, q)
		foreach (cfgs[k])
		begin
			wr(IDX_CONFIG, cfgs[k]);
			wr(IDX_GLOBAL, 8'h00);
			fr.burst(6'h3F, 5);
			fr.mark();
			wr(IDX_FRM_LO, 8'h00);
			repeat (3) @(posedge i_mclk);
			e3 = cfgs[k][0];
			ex[0] = 16'd5;
			ex[1] = 16'd5;
			ex[2] = (e3 || (cfgs[k][2] && !cfgs[k][3])) ? 16'd0 : 16'd1;
			ex[3] = (e3 && !cfgs[k][1]) ? 16'd0 : 16'd5;
			ex[4] = e3 ? 16'd0 : 16'd5;
			ex[5] = ex[3];
			chk_cnt();
			$display("mode %0h test done", cfgs[k]);
		end
		fork
			wr(IDX_GLOBAL, 8'h00);
			fr.burst(6'h20, 1);
		join
		repeat (3) @(posedge i_mclk);
		acc(1'b0, IDX_LCV_LO, 8'h00, q);
		wr(IDX_GLOBAL, 8'h00);
		repeat (3) @(posedge i_mclk);
		acc(1'b0, IDX_LCV_LO, 8'h00, q2);
		`CHK("coincident", 32'h1, q + q2)
		acc(1'b0, IDX_STATUS, 8'h00, q);
		`CHK("status_overrun", 32'h3, q)
		$display("coincident test done");
		wr(IDX_STATUS, 8'h04);
		wr(IDX_GLOBAL, 8'h00);
		repeat (3) @(negedge i_mclk);
		`CHK("irq_set", 1'b1, irq)
		acc(1'b0, IDX_STATUS, 8'h00, q);
		`CHK("status_ie", 32'h7, q)
		repeat (3) @(negedge i_mclk);
		`CHK("irq_clear", 1'b0, irq)
		acc(1'b0, 12'h300, 8'h00, q);
		`CHK("unmapped", 32'h0, q)
		$display("interrupt test done");
		finish_test();
	end
endmodule
